// File: src/psr_cfg_reg.sv
`timescale 1ns/1ps
`include "psr_cfg_consts.svh"

module psr_cfg_reg
  import psr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              linkCsN,
  input  wire logic              linkCk,
  input  wire logic [7:0]        linkDqIn,
  output logic      [7:0]        linkDqOut,
  output logic                   linkDqOe,
  input  wire logic              linkRwdsIn,
  output logic                   linkRwdsOut,
  output logic                   linkRwdsOe,
  input  wire logic              refreshReq,
  input  wire logic [15:0]       memRdData,
  output logic      [ADDR_W-1:0] memAddr,
  output logic                   memRd,
  output logic                   memWe,
  output logic      [15:0]       memWrData,
  output logic      [1:0]        memWrMask,
  output psr_cfg_s               cfgWord,
  output logic                   deepPowerDown
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [10:0] syncA;
  logic [10:0] syncB;
  logic        ckPrev;
  logic        csPrev;

  // Two stages for every pin before any logic looks at it.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      syncA  <= 11'h7ff;
      syncB  <= 11'h7ff;
      ckPrev <= 1'b1;
      csPrev <= 1'b1;
    end else begin
      syncA  <= {linkCsN, linkCk, linkRwdsIn, linkDqIn};
      syncB  <= syncA;
      ckPrev <= syncB[9];
      csPrev <= syncB[10];
    end
  end

  logic       csN;
  logic       ckEdge;
  logic       csFall;
  logic       csRise;
  logic       rwdsS;
  logic [7:0] dqS;

  // Edge detection on the synchronised link clock and chip select.
  assign csN    = syncB[10];
  assign rwdsS  = syncB[8];
  assign dqS    = syncB[7:0];
  assign ckEdge = !csN && (syncB[9] != ckPrev);
  assign csFall = !csN && csPrev;
  assign csRise = csN && !csPrev;

  // --------------------------------------------------------------------------
  // State and working registers
  // --------------------------------------------------------------------------
  psr_state_e        stateReg;
  psr_cfg_s          cfgReg;
  logic [39:0]       caReg;
  logic [47:0]       caFull;
  logic [7:0]        edgeCnt;
  logic              byteSel;
  logic              dblReg;
  logic              isRead;
  logic              isReg;
  logic              dpdTxn;
  logic [7:0]        hiByte;
  logic              hiMask;
  logic [7:0]        loByte;
  logic              advReg;
  logic              advDly;
  logic              seqLoad;
  logic [ADDR_W-1:0] seqAddr;
  logic [ADDR_W-1:0] caAddr;
  logic [ADDR_W-1:0] caAddrReg;
  logic              caLin;

  // Command decode from the six captured bytes.
  assign caFull = {caReg, dqS};
  assign caAddr = ADDR_W'({caFull[44:16], caFull[2:0]});

  logic [7:0]  latClk;
  logic [7:0]  latEdges;
  logic        regHit;
  logic [15:0] rdWord;
  logic        caLast;
  logic        latLast;
  logic        refreshSig;

  // Latency clocks from the code; reserved codes fall back to six.
  assign latClk = (cfgReg.latCode == `PSR_LAT_CODE_5) ? `PSR_LAT_CLK_5 :
                  (cfgReg.latCode == `PSR_LAT_CODE_3) ? `PSR_LAT_CLK_3 :
                  (cfgReg.latCode == `PSR_LAT_CODE_4) ? `PSR_LAT_CLK_4 : `PSR_LAT_CLK_6;
  // Two edges per clock, doubled when the strobe asked for two periods.
  assign latEdges   = dblReg ? 8'(latClk << 2) : 8'(latClk << 1);
  // Fixed mode always flags refresh; variable mode only when one is due.
  assign refreshSig = cfgReg.fixedLat | refreshReq;
  assign regHit     = (caAddrReg == ADDR_W'(`PSR_CR0_ADDR));
  assign rdWord     = isReg ? (regHit ? cfgReg : 16'h0000) : memRdData;
  assign caLast     = (edgeCnt == `PSR_CA_EDGES - 8'h01);
  assign latLast    = (edgeCnt == latEdges - 8'h01);

  // --------------------------------------------------------------------------
  // Transaction sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stateReg    <= ST_IDLE;
      cfgReg      <= `PSR_CFG_RESET;
      caReg       <= 40'h00_0000_0000;
      caAddrReg   <= '0;
      caLin       <= 1'b0;
      edgeCnt     <= 8'h00;
      byteSel     <= 1'b0;
      dblReg      <= 1'b0;
      isRead      <= 1'b0;
      isReg       <= 1'b0;
      dpdTxn      <= 1'b0;
      hiByte      <= 8'h00;
      hiMask      <= 1'b0;
      loByte      <= 8'h00;
      advReg      <= 1'b0;
      seqLoad     <= 1'b0;
      linkDqOut   <= 8'h00;
      linkDqOe    <= 1'b0;
      linkRwdsOut <= 1'b0;
      linkRwdsOe  <= 1'b0;
      memWe       <= 1'b0;
      memWrData   <= 16'h0000;
      memWrMask   <= 2'h0;
    end else begin
      advReg  <= 1'b0;
      seqLoad <= 1'b0;
      memWe   <= 1'b0;
      if (csRise) begin
        stateReg   <= ST_IDLE;
        linkDqOe   <= 1'b0;
        linkRwdsOe <= 1'b0;
        if (dpdTxn) begin
          cfgReg.normalOp <= 1'b1;
        end
        dpdTxn <= 1'b0;
      end else begin
        case (stateReg)
          ST_IDLE: begin
            if (csFall) begin
              edgeCnt <= 8'h00;
              if (!cfgReg.normalOp) begin
                dpdTxn   <= 1'b1;
                stateReg <= ST_DONE;
              end else begin
                stateReg    <= ST_CA;
                dblReg      <= refreshSig;
                linkRwdsOe  <= 1'b1;
                linkRwdsOut <= refreshSig;
              end
            end
          end
          ST_CA: begin
            if (ckEdge) begin
              caReg   <= caFull[39:0];
              edgeCnt <= edgeCnt + 8'h01;
              if (caLast) begin
                isRead  <= caFull[`PSR_CA_RW_BIT];
                isReg   <= caFull[`PSR_CA_SPACE_BIT];
                // Address and burst type are held here, the shift register moves on.
                caAddrReg <= caAddr;
                caLin     <= caFull[`PSR_CA_LINEAR_BIT];
                edgeCnt <= 8'h00;
                byteSel <= 1'b0;
                seqLoad <= 1'b1;
                if (caFull[`PSR_CA_RW_BIT]) begin
                  linkRwdsOut <= 1'b0;
                  stateReg    <= ST_LAT;
                end else begin
                  linkRwdsOe <= 1'b0;
                  // Register writes carry no latency.
                  stateReg   <= caFull[`PSR_CA_SPACE_BIT] ? ST_WDATA : ST_LAT;
                end
              end
            end
          end
          ST_LAT: begin
            if (ckEdge) begin
              edgeCnt <= edgeCnt + 8'h01;
              if (latLast) begin
                stateReg <= isRead ? ST_RDATA : ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (ckEdge) begin
              byteSel <= !byteSel;
              if (!byteSel) begin
                hiByte <= dqS;
                hiMask <= rwdsS;
              end else if (isReg) begin
                // Both bytes load as one word, never masked.
                if (regHit) begin
                  cfgReg <= {hiByte, dqS};
                end
                stateReg <= ST_DONE;
              end else begin
                memWe     <= 1'b1;
                memWrData <= {hiByte, dqS};
                memWrMask <= {hiMask, rwdsS};
                advReg    <= 1'b1;
              end
            end
          end
          ST_RDATA: begin
            if (ckEdge) begin
              byteSel  <= !byteSel;
              linkDqOe <= 1'b1;
              if (!byteSel) begin
                linkDqOut   <= rdWord[15:8];
                loByte      <= rdWord[7:0];
                linkRwdsOut <= 1'b1;
              end else begin
                linkDqOut   <= loByte;
                linkRwdsOut <= 1'b0;
                advReg      <= !isReg;
              end
            end
          end
          ST_DONE: begin
            linkDqOe   <= 1'b0;
            linkRwdsOe <= 1'b0;
          end
          default: begin
            stateReg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Memory side strobes and status outputs
  // --------------------------------------------------------------------------
  logic rdIssue;

  // Read request at the end of latency and after each word sent.
  assign rdIssue = (stateReg == ST_LAT) && ckEdge && latLast && isRead && !isReg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      advDly        <= 1'b0;
      memRd         <= 1'b0;
      memAddr       <= '0;
      cfgWord       <= `PSR_CFG_RESET;
      deepPowerDown <= 1'b0;
    end else begin
      advDly        <= advReg && isRead;
      memRd         <= rdIssue || advDly;
      memAddr       <= (memWe || rdIssue || advDly) ? seqAddr : memAddr;
      cfgWord       <= cfgReg;
      deepPowerDown <= !cfgReg.normalOp;
    end
  end

  // --------------------------------------------------------------------------
  // Burst address walker
  // --------------------------------------------------------------------------
  psr_burst_seq #(
    .ADDR_W (ADDR_W)
  ) u_seq (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .load      (seqLoad),
    .startAddr (caAddrReg),
    .wrapped   (!caLin),
    .cfg       (cfgReg),
    .advance   (advReg),
    .addr      (seqAddr)
  );

endmodule

// File: src/psr_cfg_consts.svh
`ifndef PSR_CFG_CONSTS_SVH
`define PSR_CFG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Configuration register zero layout and reset value
// ----------------------------------------------------------------------------
`define PSR_CFG_RESET        16'h8f1f
`define PSR_CFG_NORMAL_BIT   15
`define PSR_CFG_DRIVE_MSB    14
`define PSR_CFG_DRIVE_LSB    12
`define PSR_CFG_RSVD_MSB     11
`define PSR_CFG_RSVD_LSB     8
`define PSR_CFG_LAT_MSB      7
`define PSR_CFG_LAT_LSB      4
`define PSR_CFG_FIXED_BIT    3
`define PSR_CFG_LEGACY_BIT   2
`define PSR_CFG_BLEN_MSB     1
`define PSR_CFG_BLEN_LSB     0

// ----------------------------------------------------------------------------
// Register space word address of configuration register zero
// ----------------------------------------------------------------------------
`define PSR_CR0_ADDR         32'h0000_0800

// ----------------------------------------------------------------------------
// Command-address framing, in link clock edges
// ----------------------------------------------------------------------------
`define PSR_CA_EDGES         8'h06
`define PSR_CA_RW_BIT        47
`define PSR_CA_SPACE_BIT     46
`define PSR_CA_LINEAR_BIT    45

// ----------------------------------------------------------------------------
// Initial latency codes and their clock counts
// ----------------------------------------------------------------------------
`define PSR_LAT_CODE_5       4'h0
`define PSR_LAT_CODE_6       4'h1
`define PSR_LAT_CODE_3       4'he
`define PSR_LAT_CODE_4       4'hf
`define PSR_LAT_CLK_3        8'h03
`define PSR_LAT_CLK_4        8'h04
`define PSR_LAT_CLK_5        8'h05
`define PSR_LAT_CLK_6        8'h06

// ----------------------------------------------------------------------------
// Wrap group length codes, in words
// ----------------------------------------------------------------------------
`define PSR_BLEN_128B        2'h0
`define PSR_BLEN_64B         2'h1
`define PSR_BLEN_16B         2'h2
`define PSR_BLEN_32B         2'h3
`define PSR_WORDS_128B       7'h40
`define PSR_WORDS_64B        7'h20
`define PSR_WORDS_16B        7'h08
`define PSR_WORDS_32B        7'h10

`endif

// File: src/psr_pkg.sv
package psr_pkg;

  // --------------------------------------------------------------------------
  // Configuration register zero as fields.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       normalOp;
    logic [2:0] driveCode;
    logic [3:0] reserved;
    logic [3:0] latCode;
    logic       fixedLat;
    logic       legacyWrap;
    logic [1:0] burstLen;
  } psr_cfg_s;

  // --------------------------------------------------------------------------
  // Link transaction states.
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_CA    = 6'b000010,
    ST_LAT   = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_DONE  = 6'b100000
  } psr_state_e;

endpackage

// File: src/psr_burst_seq.sv
`timescale 1ns/1ps
`include "psr_cfg_consts.svh"

module psr_burst_seq
  import psr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              load,
  input  wire logic [ADDR_W-1:0] startAddr,
  input  wire logic              wrapped,
  input  wire psr_cfg_s          cfg,
  input  wire logic              advance,
  output logic      [ADDR_W-1:0] addr
);

  logic [6:0]        cntReg;
  logic              linReg;
  logic [6:0]        grpWords;
  logic [ADDR_W-1:0] grpSize;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] incWrap;
  logic              hybridJump;
  logic [ADDR_W-1:0] addrNext;

  // Group length in words from the burst length code.
  assign grpWords = (cfg.burstLen == `PSR_BLEN_128B) ? `PSR_WORDS_128B :
                    (cfg.burstLen == `PSR_BLEN_64B)  ? `PSR_WORDS_64B  :
                    (cfg.burstLen == `PSR_BLEN_16B)  ? `PSR_WORDS_16B  : `PSR_WORDS_32B;
  assign grpSize  = {{(ADDR_W-7){1'b0}}, grpWords};
  assign mask     = grpSize - {{(ADDR_W-1){1'b0}}, 1'b1};
  // Groups are aligned on word addresses.
  assign base     = addr & ~mask;
  assign incWrap  = base | ((addr + {{(ADDR_W-1){1'b0}}, 1'b1}) & mask);
  // Hybrid leaves the group after one full wrap, at the next group.
  assign hybridJump = !cfg.legacyWrap && !linReg && (cntReg == grpWords - 7'h01);
  assign addrNext = linReg ? addr + {{(ADDR_W-1){1'b0}}, 1'b1} :
                    hybridJump ? base + grpSize : incWrap;

  // Address walk; linear bursts never wrap.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr   <= '0;
      cntReg <= 7'h00;
      linReg <= 1'b0;
    end else if (load) begin
      addr   <= startAddr;
      cntReg <= 7'h00;
      linReg <= !wrapped;
    end else if (advance) begin
      addr   <= addrNext;
      cntReg <= cntReg + 7'h01;
      if (hybridJump) begin
        linReg <= 1'b1;
      end
    end
  end

endmodule

// File: verif/psr_cfg_reg_chk.sv
`timescale 1ns/1ps
`include "psr_cfg_consts.svh"

// --------------------------------
// Port checks of the register bank
// --------------------------------
module psr_cfg_reg_chk
  import psr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              linkCsN,
  input wire logic              linkCk,
  input wire logic [7:0]        linkDqIn,
  input wire logic [7:0]        linkDqOut,
  input wire logic              linkDqOe,
  input wire logic              linkRwdsIn,
  input wire logic              linkRwdsOut,
  input wire logic              linkRwdsOe,
  input wire logic              refreshReq,
  input wire logic [15:0]       memRdData,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic              memRd,
  input wire logic              memWe,
  input wire logic [15:0]       memWrData,
  input wire logic [1:0]        memWrMask,
  input wire psr_cfg_s          cfgWord,
  input wire logic              deepPowerDown
);
  // All checks use the core clock and rest while reset is applied.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_reset_default: assert property (
    $rose(rstn) |-> cfgWord == `PSR_CFG_RESET && !deepPowerDown) else $error("bad value after reset");
  chk_dpd_entry: assert property (
    $fell(cfgWord.normalOp) |-> ##[0:3] deepPowerDown) else $error("power down not entered");
  chk_dpd_cause: assert property (
    $rose(deepPowerDown) |-> ##[0:3] !cfgWord.normalOp) else $error("power down without bit clear");
  chk_dpd_exit: assert property (
    $fell(deepPowerDown) |-> linkCsN ##[0:3] cfgWord.normalOp) else $error("bad power down exit");
  chk_dpd_silent: assert property (
    deepPowerDown |-> !linkRwdsOe && !linkDqOe && !memRd && !memWe) else $error("activity in power down");
  chk_ca_strobe: assert property (
    $fell(linkCsN) && !deepPowerDown |-> ##[1:6] (linkRwdsOe && linkRwdsOut == (cfgWord.fixedLat | refreshReq)))
    else $error("wrong strobe level during command");
  chk_cfg_hold: assert property (
    linkCsN [*8] |-> $stable(cfgWord)) else $error("configuration changed while idle");
  chk_frame_quiet: assert property (
    $fell(linkCsN) |-> (!linkDqOe && !memRd && !memWe) [*8]) else $error("early activity in command phase");
endmodule

bind psr_cfg_reg psr_cfg_reg_chk #(.ADDR_W(ADDR_W)) chk (
  .core_clk(core_clk), .rstn(rstn), .linkCsN(linkCsN), .linkCk(linkCk), .linkDqIn(linkDqIn),
  .linkDqOut(linkDqOut), .linkDqOe(linkDqOe), .linkRwdsIn(linkRwdsIn), .linkRwdsOut(linkRwdsOut),
  .linkRwdsOe(linkRwdsOe), .refreshReq(refreshReq), .memRdData(memRdData), .memAddr(memAddr),
  .memRd(memRd), .memWe(memWe), .memWrData(memWrData), .memWrMask(memWrMask), .cfgWord(cfgWord),
  .deepPowerDown(deepPowerDown)
);

// File: verif/psr_host_model.sv
`timescale 1ns/1ps

// --------------------------------
// Host controller on the link
// --------------------------------
module psr_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] linkDqOut,
  input  wire logic       linkDqOe,
  input  wire logic       linkRwdsOut,
  input  wire logic       linkRwdsOe,
  output logic            linkCsN,
  output logic            linkCk,
  output logic      [7:0] linkDqIn,
  output logic            linkRwdsIn
);
  logic [7:0] dqDrv;
  logic       hostOe;

  // Released lines show the inverse of the last value; the host never drives the strobe.
  assign linkDqIn   = linkDqOe ? linkDqOut : (hostOe ? dqDrv : ~dqDrv);
  assign linkRwdsIn = linkRwdsOe ? linkRwdsOut : ~linkRwdsOut;

  // The link clock stands low between frames.
  initial begin
    linkCsN = 1'b1;
    linkCk  = 1'b0;
    dqDrv   = 8'h00;
    hostOe  = 1'b0;
  end

  // One frame: six command bytes, then totEdges clock edges, 200 ns per link clock.
  task automatic xfer(input logic [47:0] ca, input logic [15:0] wd, input int latE, input int totEdges,
                      output logic rwdsCa, output logic [15:0] rd);
    int k;
    rd     = 16'h0000;
    rwdsCa = 1'b0;
    @(posedge core_clk);
    linkCsN <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i <= totEdges + 6; i++) begin
      k = i - 7 - latE;
      hostOe <= (i < 6) || (!ca[47] && i < 8);
      if (i < 6) dqDrv <= ca[47 - 8 * i -: 8];
      else if (i < 8) dqDrv <= (i == 6) ? wd[15:8] : wd[7:0];
      @(posedge core_clk);
      @(posedge core_clk);
      if (i < totEdges + 6) linkCk <= ~linkCk;
      @(negedge core_clk);
      if (i == 3) rwdsCa = linkRwdsOe ? linkRwdsOut : 1'bx;
      if (ca[47] && k >= 0 && k < 2) rd = {rd[7:0], linkDqIn};
      @(posedge core_clk);
      @(posedge core_clk);
    end
    linkCsN <= 1'b1;
    hostOe  <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// File: verif/psr_cfg_reg_tb.sv
`timescale 1ns/1ps
`include "psr_cfg_consts.svh"

// --------------------------------
// Register bank bench
// --------------------------------
module psr_cfg_reg_tb
  import psr_pkg::*;
;
  logic        core_clk, rstn, refreshReq, memRd, memWe, deepPowerDown, rwTmp;
  logic        linkCsN, linkCk, linkDqOe, linkRwdsIn, linkRwdsOut, linkRwdsOe;
  logic [7:0]  linkDqIn, linkDqOut;
  logic [15:0] memRdData, memWrData, wv, rdTmp;
  logic [31:0] memAddr;
  logic [31:0] rdAddrQ[$];
  logic [1:0]  memWrMask;
  logic [3:0]  latCodes[4] = '{4'h0, 4'h1, 4'he, 4'hf};
  int          wordsTab[4] = '{64, 32, 8, 16};
  psr_cfg_s    cfgWord, shadow;
  int          fail_count, num_checks;

  psr_cfg_reg #(.ADDR_W(32)) dut (
    .core_clk(core_clk), .rstn(rstn), .linkCsN(linkCsN), .linkCk(linkCk), .linkDqIn(linkDqIn),
    .linkDqOut(linkDqOut), .linkDqOe(linkDqOe), .linkRwdsIn(linkRwdsIn), .linkRwdsOut(linkRwdsOut),
    .linkRwdsOe(linkRwdsOe), .refreshReq(refreshReq), .memRdData(memRdData), .memAddr(memAddr),
    .memRd(memRd), .memWe(memWe), .memWrData(memWrData), .memWrMask(memWrMask), .cfgWord(cfgWord),
    .deepPowerDown(deepPowerDown));
  psr_host_model host (
    .core_clk(core_clk), .linkDqOut(linkDqOut), .linkDqOe(linkDqOe), .linkRwdsOut(linkRwdsOut),
    .linkRwdsOe(linkRwdsOe), .linkCsN(linkCsN), .linkCk(linkCk), .linkDqIn(linkDqIn), .linkRwdsIn(linkRwdsIn));

  // Core clock, 25 ns period.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The array answers well within four cycles and addresses of read strobes are logged.
  always @(posedge core_clk) begin
    memRdData <= memAddr[15:0] ^ 16'h5a5a;
    if (memRd === 1'b1) rdAddrQ.push_back(memAddr);
  end

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkFlag(input logic got, input logic exp);
    checkVal({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [47:0] mkCa(input logic rd, input logic regSp, input logic lin, input logic [31:0] a);
    return {rd, regSp, lin, a[31:3], 13'h0000, a[2:0]};
  endfunction

  // Latency edges: two per clock, doubled when the strobe flags refresh.
  function automatic int latEdges(input psr_cfg_s c, input logic refresh);
    int n;
    case (c.latCode)
      4'h0: n = 5;
      4'he: n = 3;
      4'hf: n = 4;
      default: n = 6;
    endcase
    return 2 * n * ((c.fixedLat | refresh) ? 2 : 1);
  endfunction

  task automatic regWr(input logic [31:0] a, input logic [15:0] d);
    host.xfer(mkCa(1'b0, 1'b1, 1'b1, a), d, 0, 2, rwTmp, rdTmp);
    if (a == `PSR_CR0_ADDR) shadow = d;
  endtask

  task automatic regRd(input logic [31:0] a, input logic [15:0] exp);
    int le;
    le = latEdges(shadow, refreshReq);
    host.xfer(mkCa(1'b1, 1'b1, 1'b1, a), 16'h0000, le, le + 2, rwTmp, rdTmp);
    checkFlag(rwTmp, shadow.fixedLat | refreshReq);
    checkVal(rdTmp, exp);
  endtask

  // Wrapped read; past one group a hybrid burst runs on linearly, so its address is base plus k.
  task automatic arrRd(input logic [31:0] start, input int words, input int n);
    logic [31:0] base;
    int          le;
    le = latEdges(shadow, refreshReq);
    base = start & ~(words - 1);
    rdAddrQ.delete();
    host.xfer(mkCa(1'b1, 1'b0, 1'b0, start), 16'h0000, le, le + 2 * n, rwTmp, rdTmp);
    for (int k = 0; k < n; k++) begin
      checkVal((k < rdAddrQ.size()) ? rdAddrQ[k] : 32'hffff_ffff,
               (!shadow.legacyWrap && k >= words) ? base + k : base + ((start - base + k) % words));
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard.
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    refreshReq = 1'b0;
    memRdData = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    shadow = `PSR_CFG_RESET;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    checkVal(cfgWord, `PSR_CFG_RESET);
    checkFlag(deepPowerDown, 1'b0);
    regRd(`PSR_CR0_ADDR, `PSR_CFG_RESET);
    $display("test reset_defaults done");
    for (int j = 0; j < 8; j++) begin
      refreshReq <= j[1];
      wv = {1'b1, 3'(j), 4'hf, latCodes[j % 4], j[0], 1'b1, 2'(j)};
      regWr(`PSR_CR0_ADDR, wv);
      checkVal(cfgWord, wv);
      regRd(`PSR_CR0_ADDR, wv);
    end
    $display("test field_sweep done");
    refreshReq <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      wv = {1'b1, 3'h0, 4'hf, 4'he, 1'b0, j[2], 2'(j)};
      regWr(`PSR_CR0_ADDR, wv);
      arrRd(32'h0000_012e, wordsTab[j % 4], wordsTab[j % 4] + 4);
    end
    $display("test burst_order done");
    regWr(32'h0000_0801, 16'h0000);
    checkVal(cfgWord, wv);
    regRd(32'h0000_0801, 16'h0000);
    $display("test unmapped done");
    regWr(`PSR_CR0_ADDR, 16'h0fe3);
    checkFlag(deepPowerDown, 1'b1);
    host.xfer(mkCa(1'b1, 1'b1, 1'b1, `PSR_CR0_ADDR), 16'h0000, 0, 0, rwTmp, rdTmp);
    checkFlag(deepPowerDown, 1'b0);
    checkVal(cfgWord, 16'h8fe3);
    shadow = 16'h8fe3;
    regRd(`PSR_CR0_ADDR, 16'h8fe3);
    $display("test power_down done");
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    shadow = `PSR_CFG_RESET;
    repeat (4) @(posedge core_clk);
    checkVal(cfgWord, `PSR_CFG_RESET);
    regRd(`PSR_CR0_ADDR, `PSR_CFG_RESET);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule
